// ==== src/tws_map.vh ====
/*
  Register offsets, field positions, reset values and bit-slot numbers of the two-wire status block.
  Assumes inclusion by bare name from a file compiled after it.
*/
`ifndef TWS_MAP_VH
`define TWS_MAP_VH
// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define TWS_OFF_STAT 8'h00
`define TWS_OFF_CTRL 8'h04
`define TWS_OFF_OWN 8'h08
`define TWS_OFF_MODE 8'h0C
`define TWS_OFF_DATA 8'h10
`define TWS_OFF_ISTAT 8'h14
`define TWS_OFF_IMASK 8'h18
// ----------------------------------------
// Status fields
// ----------------------------------------
`define TWS_ST_FIXED 8'h30
`define TWS_ST_IRQ 6
`define TWS_ST_AL 3
`define TWS_ST_AAS 2
`define TWS_ST_ADZ 1
`define TWS_ST_ACK 0
// ----------------------------------------
// Shared control fields
// ----------------------------------------
`define TWS_CTRL_RESET 8'h00
`define TWS_CTRL_RSEL 7
`define TWS_CTRL_RRES 6
`define TWS_CTRL_RATEX 5
`define TWS_CTRL_ACCEN 4
`define TWS_CTRL_HSW 3
`define TWS_CTRL_MPE 2
`define TWS_CTRL_TSHI 1
`define TWS_CTRL_TSLO 0
// ----------------------------------------
// Mode and own address fields
// ----------------------------------------
`define TWS_MODE_TX 0
`define TWS_MODE_MST 1
`define TWS_MODE_CKS_LO 2
`define TWS_MODE_CKS_HI 4
`define TWS_OWN_FS 0
`define TWS_GCALL 8'h00
// ----------------------------------------
// Frame slots, events, responses
// ----------------------------------------
`define TWS_LEAD_BIT 4'hF
`define TWS_LAST_BIT 4'h7
`define TWS_ACK_SLOT 4'h8
`define TWS_EV_AL 0
`define TWS_EV_ADDR 1
`define TWS_EV_BYTE 2
`define TWS_RESP_OKAY 2'h0
`define TWS_RESP_SLVERR 2'h2
`endif

// ==== src/tws_flags.v ====
/*
  Two-wire bus status flags, shared control register, small bit engine and AXI4-Lite register slave.
  Assumes open-drain SCL/SDA resolved outside, pins asynchronous to aclk, hw_standby from aclk logic.
*/
`timescale 1ns/100ps
`include "tws_map.vh"

//Contract
//[RL1] Master transmit: data mismatch at SCL rise loses
//[RL2] Master transmit: internal SCL high at fall loses
//[RL3] Data access in current direction clears lost flag
//[RL4] Write zero clears lost only after read
//[RL5] Slave receive addressing: own/general match sets flag
//[RL6] Match flag cleared by read-write zero, data
//[RL7] First byte all zero sets general-call flag
//[RL8] General-call flag cleared like match flag
//[RL9] Transmit: capture receiver acknowledge into ack bit
//[RL10] Receive: drive written ack bit in slot
//[RL11] Ack read: captured if transmit, else written
//[RL12] Shared control eight bits, zero on reset/standby
//[RL13] Upper two bits stored and readable
//[RL14] Rate extend plus clock field set rate
//[RL15] Access enable gates interface register access
//[RL16] Other shared bits stored and exported only
//[RL17] Lost flag also sets interrupt request flag
//[RL18] Status resets to bits five, four high
//[RL19] Set wins over clear same cycle
module tws_flags #(
  parameter ADDR_W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire hw_standby,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire scl_i,
  output wire scl_o,
  output reg scl_oe,
  input wire sda_i,
  output wire sda_o,
  output reg sda_oe,
  output wire irq,
  output wire host_input_switch,
  output wire multiproc_enable,
  output wire timer_src_select_hi,
  output wire timer_src_select_lo,
  output wire reserved_buffer_select,
  output wire reserved_buffer_reserve
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  wire rst = !aresetn || hw_standby;
  reg [7:0] ctrl_r;
  reg [7:0] own_r;
  reg [7:0] mode_r;
  reg al_r, aas_r, adz_r, iface_irq_flag_r;
  reg al_seen_r, aas_seen_r, adz_seen_r, iface_irq_flag_seen_r;
  reg ack_sw_r, ack_cap_r;
  reg [2:0] istat_r;
  reg [2:0] imask_r;
  reg scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
  reg in_frame_r, first_r, addressed_r, xfer_r, scl_int_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] div_r;
  reg [7:0] tx_shift_r, rx_shift_r, rx_data_r, tx_data_r;
  reg aw_have_r, w_have_r;
  reg [ADDR_W-1:0] awaddr_r;
  reg [7:0] wdata_r;
  reg wlane_r;

  wire tx = mode_r[`TWS_MODE_TX];
  wire mst = mode_r[`TWS_MODE_MST];
  wire acc_en = ctrl_r[`TWS_CTRL_ACCEN];
  wire [3:0] rate_sel = {ctrl_r[`TWS_CTRL_RATEX], mode_r[`TWS_MODE_CKS_HI:`TWS_MODE_CKS_LO]};
  wire [7:0] half_lim = {rate_sel, 4'hF}; // [RL14]

  // ----------------------------------------
  // Bus slave handshake
  // ----------------------------------------
  assign s_axi_awready = ce && !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_have_r && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire wr_go = ce && aw_have_r && w_have_r && !s_axi_bvalid;

  // Interface registers are closed while access is disabled
  function is_iface;
    input [ADDR_W-1:0] a;
    begin
      is_iface = (a[7:0] == `TWS_OFF_STAT) || (a[7:0] == `TWS_OFF_OWN) ||
                 (a[7:0] == `TWS_OFF_MODE) || (a[7:0] == `TWS_OFF_DATA);
    end
  endfunction
  function is_mapped;
    input [ADDR_W-1:0] a;
    begin
      is_mapped = is_iface(a) || (a[7:0] == `TWS_OFF_CTRL) ||
                  (a[7:0] == `TWS_OFF_ISTAT) || (a[7:0] == `TWS_OFF_IMASK);
    end
  endfunction

  wire wr_ok = wr_go && wlane_r && is_mapped(awaddr_r) && (acc_en || !is_iface(awaddr_r)); // [RL15]
  wire rd_ok = ar_hs && is_mapped(s_axi_araddr) && (acc_en || !is_iface(s_axi_araddr)); // [RL15]
  wire wr_stat = wr_ok && (awaddr_r[7:0] == `TWS_OFF_STAT);
  wire rd_stat = rd_ok && (s_axi_araddr[7:0] == `TWS_OFF_STAT);
  wire wr_data = wr_ok && (awaddr_r[7:0] == `TWS_OFF_DATA);
  wire rd_data = rd_ok && (s_axi_araddr[7:0] == `TWS_OFF_DATA);
  wire data_clr = (wr_data && tx) || (rd_data && !tx); // [RL3] [RL6] [RL8]

  // ----------------------------------------
  // Pin sampling and bus events
  // ----------------------------------------
  wire scl_rise = scl_s_r && !scl_d_r;
  wire scl_fall = !scl_s_r && scl_d_r;
  wire start_ev = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  wire stop_ev = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
  wire data_slot = in_frame_r && (bit_cnt_r < `TWS_ACK_SLOT);
  wire active = mst ? xfer_r : addressed_r;
  wire addr_done = in_frame_r && scl_fall && (bit_cnt_r == `TWS_LAST_BIT) && first_r;
  wire slave_rx_addr = addr_done && !mst && !tx && !own_r[`TWS_OWN_FS];
  wire gcall_hit = slave_rx_addr && (rx_shift_r == `TWS_GCALL); // [RL7]
  wire own_hit = slave_rx_addr && (rx_shift_r[7:1] == own_r[7:1]);
  wire match_ev = own_hit || gcall_hit; // [RL5]
  wire lose_data = mst && tx && xfer_r && scl_rise && data_slot && (tx_shift_r[7] != sda_s_r); // [RL1]
  wire lose_clk = mst && tx && xfer_r && scl_fall && scl_int_r; // [RL2]
  wire al_ev = lose_data || lose_clk;
  wire byte_ev = in_frame_r && scl_fall && (bit_cnt_r == `TWS_ACK_SLOT) && active;
  wire drv_tx = tx && active && data_slot && !tx_shift_r[7];
  wire drv_ack = !tx && (active || match_ev) && in_frame_r && (bit_cnt_r == `TWS_ACK_SLOT) && !ack_sw_r; // [RL10]

  always @(posedge aclk) begin
    if (!aresetn) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (ce) begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // ----------------------------------------
  // Bit engine
  // ----------------------------------------
  always @(posedge aclk) begin
    if (rst) begin
      in_frame_r <= 1'b0;
      first_r <= 1'b0;
      addressed_r <= 1'b0;
      xfer_r <= 1'b0;
      scl_int_r <= 1'b1;
      bit_cnt_r <= 4'h0;
      div_r <= 8'h00;
      tx_shift_r <= 8'hFF;
      rx_shift_r <= 8'h00;
      rx_data_r <= 8'h00;
      tx_data_r <= 8'h00;
      ack_cap_r <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      scl_oe <= !scl_int_r;
      sda_oe <= drv_tx || drv_ack;
      if (wr_data) begin
        tx_data_r <= wdata_r;
        tx_shift_r <= wdata_r;
      end
      // Master clock only runs while a byte is owed; it parks low after each byte and is released at a stop
      if (al_ev) begin
        xfer_r <= 1'b0;
        scl_int_r <= 1'b1;
      end else if (mst && ((wr_data && tx) || (rd_data && !tx))) begin
        xfer_r <= 1'b1;
        div_r <= 8'h00;
      end else if (xfer_r) begin
        if (div_r == half_lim) begin
          div_r <= 8'h00;
          scl_int_r <= !scl_int_r;
        end else begin
          div_r <= div_r + 8'h01;
        end
      end
      if (start_ev) begin
        in_frame_r <= 1'b1;
        first_r <= 1'b1;
        addressed_r <= 1'b0;
        bit_cnt_r <= `TWS_LEAD_BIT; // SCL fall closing a start is not a bit
      end else if (stop_ev) begin
        in_frame_r <= 1'b0;
        addressed_r <= 1'b0;
        xfer_r <= 1'b0;
        scl_int_r <= 1'b1;
      end else if (in_frame_r) begin
        if (scl_rise && data_slot) begin
          rx_shift_r <= {rx_shift_r[6:0], sda_s_r};
        end
        if (scl_rise && (bit_cnt_r == `TWS_ACK_SLOT) && tx) begin
          ack_cap_r <= sda_s_r; // [RL9]
        end
        if (match_ev) begin
          addressed_r <= 1'b1;
        end
        if (scl_fall) begin
          if (bit_cnt_r == `TWS_ACK_SLOT) begin
            bit_cnt_r <= 4'h0;
            first_r <= 1'b0;
            rx_data_r <= rx_shift_r;
            if (mst) begin
              xfer_r <= 1'b0;
            end
          end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (tx && !wr_data && data_slot) begin
              tx_shift_r <= {tx_shift_r[6:0], 1'b1};
            end
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // A write of zero counts only after the flag was seen as one
  wire wz_al = wr_stat && !wdata_r[`TWS_ST_AL] && al_seen_r; // [RL4]
  wire wz_aas = wr_stat && !wdata_r[`TWS_ST_AAS] && aas_seen_r; // [RL6]
  wire wz_adz = wr_stat && !wdata_r[`TWS_ST_ADZ] && adz_seen_r; // [RL8]
  wire wz_irq = wr_stat && !wdata_r[`TWS_ST_IRQ] && iface_irq_flag_seen_r;
  wire irq_ev = al_ev || match_ev || byte_ev;

  always @(posedge aclk) begin
    if (rst) begin
      al_r <= 1'b0; // [RL18]
      aas_r <= 1'b0;
      adz_r <= 1'b0;
      iface_irq_flag_r <= 1'b0;
      al_seen_r <= 1'b0;
      aas_seen_r <= 1'b0;
      adz_seen_r <= 1'b0;
      iface_irq_flag_seen_r <= 1'b0;
      ack_sw_r <= 1'b0;
    end else if (ce) begin
      al_r <= al_ev || (al_r && !(data_clr || wz_al)); // [RL1] [RL2] [RL3] [RL19]
      aas_r <= match_ev || (aas_r && !(data_clr || wz_aas)); // [RL5] [RL6] [RL19]
      adz_r <= gcall_hit || (adz_r && !(data_clr || wz_adz)); // [RL7] [RL8] [RL19]
      iface_irq_flag_r <= irq_ev || (iface_irq_flag_r && !wz_irq); // [RL17] [RL19]
      if (wr_stat) begin
        ack_sw_r <= wdata_r[`TWS_ST_ACK];
        al_seen_r <= 1'b0;
        aas_seen_r <= 1'b0;
        adz_seen_r <= 1'b0;
        iface_irq_flag_seen_r <= 1'b0;
      end else if (rd_stat) begin
        al_seen_r <= al_seen_r || al_r;
        aas_seen_r <= aas_seen_r || aas_r;
        adz_seen_r <= adz_seen_r || adz_r;
        iface_irq_flag_seen_r <= iface_irq_flag_seen_r || iface_irq_flag_r;
      end
    end
  end

  wire ack_rd = tx ? ack_cap_r : ack_sw_r; // [RL11]
  wire [7:0] stat_rd = `TWS_ST_FIXED | {1'b0, iface_irq_flag_r, 2'b00, al_r, aas_r, adz_r, ack_rd}; // [RL18]

  // ----------------------------------------
  // Control, interrupt and bus answers
  // ----------------------------------------
  wire [2:0] ev_vec = {byte_ev, match_ev, al_ev};
  wire wr_istat = wr_ok && (awaddr_r[7:0] == `TWS_OFF_ISTAT);

  always @(posedge aclk) begin
    if (rst) begin
      ctrl_r <= `TWS_CTRL_RESET; // [RL12] [RL13]
      own_r <= 8'h00;
      mode_r <= 8'h00;
      istat_r <= 3'h0;
      imask_r <= 3'h0;
    end else if (ce) begin
      istat_r <= ev_vec | (istat_r & ~(wr_istat ? wdata_r[2:0] : 3'h0)); // [RL19]
      if (wr_ok) begin
        case (awaddr_r[7:0])
          `TWS_OFF_CTRL: ctrl_r <= wdata_r; // [RL12] [RL13] [RL16]
          `TWS_OFF_OWN: own_r <= wdata_r;
          `TWS_OFF_MODE: mode_r <= wdata_r;
          `TWS_OFF_IMASK: imask_r <= wdata_r[2:0];
          default: ;
        endcase
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= {ADDR_W{1'b0}};
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TWS_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `TWS_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else if (ce) begin
      if (aw_hs) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (is_mapped(awaddr_r) && (acc_en || !is_iface(awaddr_r))) ?
                       `TWS_RESP_OKAY : `TWS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_ok ? `TWS_RESP_OKAY : `TWS_RESP_SLVERR;
        s_axi_rdata <= 32'h00000000;
        if (rd_ok) begin
          case (s_axi_araddr[7:0])
            `TWS_OFF_STAT: s_axi_rdata <= {24'h000000, stat_rd};
            `TWS_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl_r};
            `TWS_OFF_OWN: s_axi_rdata <= {24'h000000, own_r};
            `TWS_OFF_MODE: s_axi_rdata <= {24'h000000, mode_r};
            `TWS_OFF_DATA: s_axi_rdata <= {24'h000000, tx ? tx_data_r : rx_data_r};
            `TWS_OFF_ISTAT: s_axi_rdata <= {29'h00000000, istat_r};
            `TWS_OFF_IMASK: s_axi_rdata <= {29'h00000000, imask_r};
            default: s_axi_rdata <= 32'h00000000;
          endcase
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign irq = |(istat_r & imask_r);
  assign host_input_switch = ctrl_r[`TWS_CTRL_HSW]; // [RL16]
  assign multiproc_enable = ctrl_r[`TWS_CTRL_MPE]; // [RL16]
  assign timer_src_select_hi = ctrl_r[`TWS_CTRL_TSHI]; // [RL16]
  assign timer_src_select_lo = ctrl_r[`TWS_CTRL_TSLO]; // [RL16]
  assign reserved_buffer_select = ctrl_r[`TWS_CTRL_RSEL]; // [RL13]
  assign reserved_buffer_reserve = ctrl_r[`TWS_CTRL_RRES]; // [RL13]
endmodule // tws_flags

// ==== tb/tws_flags_asserts.sv ====
/*
  Checker for the two-wire status block: register bus answers and standby clearing.
  Assumes binding to tws_flags with the clock enable held high.
*/
`timescale 1ns/100ps
module tws_flags_asserts (
  input wire aclk,
  input wire aresetn,
  input wire hw_standby,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire scl_oe,
  input wire sda_oe,
  input wire irq,
  input wire host_input_switch,
  input wire multiproc_enable
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_give;
    s_axi_rvalid && s_axi_rready;
  endsequence
  AST_RD_ANSWER: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  AST_RD_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  AST_WR_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed");
  AST_RD_ONE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken while answer pending");
  AST_RD_DONE: assert property (s_rd_give |=> !s_axi_rvalid)
    else $error("read answer kept after acceptance");
  AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  AST_BYTE_WIDE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above bit 7");
  AST_STBY_CTRL: assert property (hw_standby |=> !host_input_switch && !multiproc_enable && !irq)
    else $error("standby left control or interrupt set");
  AST_STBY_PINS: assert property (hw_standby |=> !scl_oe && !sda_oe)
    else $error("standby left a line pulled low");
endmodule // tws_flags_asserts

bind tws_flags tws_flags_asserts i_tws_flags_asserts (.aclk, .aresetn, .hw_standby, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .scl_oe, .sda_oe, .irq, .host_input_switch, .multiproc_enable);

// ==== tb/tws_bus_peer.sv ====
/*
  Behavioural far-side party on the two-wire bus: a master sending frames, or a line jammer.
  Assumes pull-ups, so a line reads high unless some party pulls it low.
*/
`timescale 1ns/100ps
module tws_bus_peer (
  input wire scl_oe,
  input wire sda_oe,
  output wire scl_line,
  output wire sda_line
);
  reg sl = 1'b0;
  reg dl = 1'b0;
  // Open drain: any puller wins
  assign scl_line = !(scl_oe | sl);
  assign sda_line = !(sda_oe | dl);
  task start;
    begin
      sl = 1'b0;
      dl = 1'b0;
      #80 dl = 1'b1;
      #40 sl = 1'b1;
    end
  endtask
  // 80 ns bit period; data set well before the rise
  task send(input [7:0] b, output a);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sl = 1'b1;
        #10 dl = ~b[i];
        #30 sl = 1'b0;
        #40;
      end
      sl = 1'b1;
      #10 dl = 1'b0;
      #30 sl = 1'b0;
      #20 a = sda_line;
      #20 sl = 1'b1;
    end
  endtask
  // Stop leaves both lines released, so a master in the block can clock
  task stop;
    begin
      dl = 1'b1;
      #20 sl = 1'b0;
      #40 dl = 1'b0;
      #40;
    end
  endtask
  task jam(input v);
    dl = v;
  endtask
endmodule // tws_bus_peer

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the two-wire status block over its register bus and bus lines.
  Assumes the peer model holds the far side and the clock enable stays high.
*/
`timescale 1ns/100ps
`include "tws_map.vh"
module testbench;
  logic aclk, aresetn = 1'b0, ce = 1'b1, hw_standby = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire scl_line, sda_line, scl_oe, sda_oe, irq, host_input_switch, multiproc_enable;
  wire timer_src_select_hi, timer_src_select_lo, reserved_buffer_select, reserved_buffer_reserve;
  integer failures = 0;
  integer checks_done = 0;
  reg a;
  tws_flags i_tws_flags (.aclk, .aresetn, .ce, .hw_standby, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .scl_i(scl_line), .scl_o(), .scl_oe, .sda_i(sda_line), .sda_o(), .sda_oe, .irq, .host_input_switch,
    .multiproc_enable, .timer_src_select_hi, .timer_src_select_lo, .reserved_buffer_select,
    .reserved_buffer_reserve);
  tws_bus_peer i_tws_bus_peer (.scl_oe, .sda_oe, .scl_line, .sda_line);
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task ck(input string n, input [31:0] e, input [31:0] s);
    checks_done = checks_done + 1;
    if (s !== e) begin
      failures = failures + 1;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input [7:0] ad, input [7:0] d);
    reg pa, pw;
    begin
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa | pw) begin
        @(negedge aclk);
        pa = pa & !s_axi_awready;
        pw = pw & !s_axi_wready;
        @(posedge aclk);
        if (!pa) s_axi_awvalid <= 1'b0;
        if (!pw) s_axi_wvalid <= 1'b0;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      ck("bresp", `TWS_RESP_OKAY, s_axi_bresp);
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input string n, input [7:0] ad, input [7:0] m, input [7:0] e, input [1:0] er);
    reg [31:0] q;
    begin
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      q = s_axi_rdata;
      ck("rresp", er, s_axi_rresp);
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      ck(n, {24'h0, e}, q & {24'h0, m});
    end
  endtask
  task wirq;
    integer i;
    for (i = 0; i < 700 && irq !== 1'b1; i = i + 1) @(negedge aclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    rd("ctrl", `TWS_OFF_CTRL, 8'hFF, 8'h00, `TWS_RESP_OKAY);
    rd("stat", `TWS_OFF_STAT, 8'h00, 8'h00, `TWS_RESP_SLVERR);
    rd("hole", 8'h1C, 8'h00, 8'h00, `TWS_RESP_SLVERR);
    wr(`TWS_OFF_CTRL, 8'hC0);
    rd("ctrl", `TWS_OFF_CTRL, 8'hFF, 8'hC0, `TWS_RESP_OKAY);
    ck("resv", 32'h3, {30'h0, reserved_buffer_select, reserved_buffer_reserve});
    wr(`TWS_OFF_CTRL, 8'h1F);
    ck("exp", 32'hF, {28'h0, host_input_switch, multiproc_enable, timer_src_select_hi, timer_src_select_lo});
    hw_standby <= 1'b1;
    @(posedge aclk);
    hw_standby <= 1'b0;
    rd("ctrl", `TWS_OFF_CTRL, 8'hFF, 8'h00, `TWS_RESP_OKAY);
    wr(`TWS_OFF_CTRL, 8'h10);
    rd("stat", `TWS_OFF_STAT, 8'hFF, 8'h30, `TWS_RESP_OKAY);
    $display("test regs done");
  endtask
  task t_slave;
    wr(`TWS_OFF_OWN, 8'h54);
    wr(`TWS_OFF_MODE, 8'h00);
    i_tws_bus_peer.start;
    i_tws_bus_peer.send(8'h54, a);
    ck("ack", 32'h0, {31'h0, a});
    wr(`TWS_OFF_STAT, 8'h00);
    rd("stat", `TWS_OFF_STAT, 8'h06, 8'h04, `TWS_RESP_OKAY);
    wr(`TWS_OFF_STAT, 8'h00);
    rd("stat", `TWS_OFF_STAT, 8'h06, 8'h00, `TWS_RESP_OKAY);
    i_tws_bus_peer.start;
    i_tws_bus_peer.send(8'h00, a);
    rd("stat", `TWS_OFF_STAT, 8'h06, 8'h06, `TWS_RESP_OKAY);
    rd("data", `TWS_OFF_DATA, 8'h00, 8'h00, `TWS_RESP_OKAY);
    rd("stat", `TWS_OFF_STAT, 8'h06, 8'h00, `TWS_RESP_OKAY);
    wr(`TWS_OFF_STAT, 8'h01);
    rd("stat", `TWS_OFF_STAT, 8'h01, 8'h01, `TWS_RESP_OKAY);
    i_tws_bus_peer.start;
    i_tws_bus_peer.send(8'h54, a);
    ck("nack", 32'h1, {31'h0, a});
    i_tws_bus_peer.stop;
    $display("test slave done");
  endtask
  task t_arb;
    wr(`TWS_OFF_STAT, 8'h00);
    wr(`TWS_OFF_IMASK, 8'h01);
    wr(`TWS_OFF_MODE, 8'h03);
    i_tws_bus_peer.jam(1'b1);
    wr(`TWS_OFF_DATA, 8'hFF);
    wirq;
    ck("irq", 32'h1, {31'h0, irq});
    i_tws_bus_peer.jam(1'b0);
    rd("stat", `TWS_OFF_STAT, 8'h48, 8'h48, `TWS_RESP_OKAY);
    wr(`TWS_OFF_IMASK, 8'h00);
    ck("irq", 32'h0, {31'h0, irq});
    wr(`TWS_OFF_ISTAT, 8'h05);
    wr(`TWS_OFF_IMASK, 8'h04);
    // Jam makes the start; once the block drives its zero bits the jam can go
    i_tws_bus_peer.jam(1'b1);
    wr(`TWS_OFF_DATA, 8'h00);
    do @(negedge aclk); while (sda_oe !== 1'b1);
    i_tws_bus_peer.jam(1'b0);
    rd("stat", `TWS_OFF_STAT, 8'h08, 8'h00, `TWS_RESP_OKAY);
    wirq;
    ck("done", 32'h1, {31'h0, irq});
    rd("stat", `TWS_OFF_STAT, 8'h01, 8'h01, `TWS_RESP_OKAY);
    wr(`TWS_OFF_ISTAT, 8'h04);
    ck("irq", 32'h0, {31'h0, irq});
    $display("test arb done");
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Whole run needs about a thousand cycles
  initial begin
    #400000;
    failures = failures + 1;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_slave;
    t_arb;
    give_verdict;
  end
endmodule // testbench
